// ==== core/aacr_pkg.sv ====
// aacr_pkg: register map, field positions, reset values and decode constants
// for the amplifier control register bank; used by aacr_reg_store and aacr_ctrl_regs.
package aacr_pkg;
    localparam logic [7:0] ADDR_DIG_CTRL   = 8'h02;
    localparam logic [7:0] ADDR_VOL_CFG    = 8'h03;
    localparam logic [7:0] ADDR_LEFT_VOL   = 8'h04;
    localparam logic [7:0] ADDR_RIGHT_VOL  = 8'h05;
    localparam logic [7:0] ADDR_OUT_STAGE  = 8'h06;
    localparam logic [7:0] ADDR_RSVD_SLOT  = 8'h07;

    localparam logic [7:0] RST_DIG_CTRL    = 8'h14;
    localparam logic [7:0] RST_VOL_CFG     = 8'h80;
    localparam logic [7:0] RST_VOLUME      = 8'hcf;
    localparam logic [7:0] RST_OUT_STAGE   = 8'h51;
    localparam logic [7:0] RST_RSVD_SLOT   = 8'h00;

    // writable-bit masks; other bits are read-only reserved
    localparam logic [7:0] WMASK_DIG_CTRL  = 8'hbf;
    localparam logic [7:0] WMASK_VOL_CFG   = 8'h83;
    localparam logic [7:0] WMASK_FULL      = 8'hff;
    localparam logic [7:0] WMASK_OUT_STAGE = 8'hfe;

    localparam int HPF_BYP_BIT    = 7;
    localparam int BOOST_LSB      = 4;
    localparam int SPEED_BIT      = 3;
    localparam int FMT_LSB        = 0;
    localparam int FADE_BIT       = 7;
    localparam int MUTE_R_BIT     = 1;
    localparam int MUTE_L_BIT     = 0;
    localparam int PARALLEL_BRIDGE_MODE_BIT       = 7;
    localparam int RATE_LSB       = 4;
    localparam int AGAIN_LSB      = 2;
    localparam int CHSEL_BIT      = 1;

    localparam logic [7:0] VOL_MUTE_LIMIT = 8'h07;
    localparam logic [7:0] VOL_ZERO_DB    = 8'hcf;

    typedef enum logic [2:0] {
        AACR_FMT_RJ24 = 3'b000,
        AACR_FMT_RJ20 = 3'b001,
        AACR_FMT_RJ18 = 3'b010,
        AACR_FMT_RJ16 = 3'b011,
        AACR_FMT_I2S  = 3'b100,
        AACR_FMT_LJ   = 3'b101
    } aacr_fmt_e;
endpackage

// ==== core/aacr_reg_if.sv ====
// aacr_reg_if: byte-wide register access carried from the bank to its storage.
// assumes one clock domain, single-cycle write strobe.
`timescale 1ns/1ps
interface aacr_reg_if;
    logic       wr_en;
    logic [2:0] wr_idx;
    logic [7:0] wr_data;
    logic [2:0] rd_idx;
    logic [7:0] rd_data;
    modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
    modport store (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface

// ==== core/aacr_reg_store.sv ====
// aacr_reg_store: six byte registers at slots 0..5 with per-slot write masks.
// assumes write strobe and indices from the same clock; read data registered.
`timescale 1ns/1ps
module aacr_reg_store (
    input  wire logic i_sys_clk,
    input  wire logic i_rst,
    aacr_reg_if.store bus,
    output logic [7:0] o_slot [6]
);
    localparam logic [7:0] RST_V [6] = '{aacr_pkg::RST_DIG_CTRL, aacr_pkg::RST_VOL_CFG, aacr_pkg::RST_VOLUME,
                                         aacr_pkg::RST_VOLUME, aacr_pkg::RST_OUT_STAGE, aacr_pkg::RST_RSVD_SLOT};
    localparam logic [7:0] MASK_V [6] = '{aacr_pkg::WMASK_DIG_CTRL, aacr_pkg::WMASK_VOL_CFG, aacr_pkg::WMASK_FULL,
                                          aacr_pkg::WMASK_FULL, aacr_pkg::WMASK_OUT_STAGE, aacr_pkg::WMASK_FULL};

    logic [7:0] slot_ff [6];
    logic [7:0] rd_ff;

    always_ff @(posedge i_sys_clk) begin
        for (int i = 0; i < 6; i++) begin
            if (i_rst) begin
                slot_ff[i] <= RST_V[i];
            end else if (bus.wr_en && bus.wr_idx == 3'(i)) begin
                slot_ff[i] <= (bus.wr_data & MASK_V[i]) | (RST_V[i] & ~MASK_V[i]);
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            rd_ff <= 8'h00;
        end else if (bus.rd_idx < 3'd6) begin
            rd_ff <= slot_ff[bus.rd_idx];
        end else begin
            rd_ff <= 8'h00;
        end
    end

    assign bus.rd_data = rd_ff;
    assign o_slot      = slot_ff;
endmodule // aacr_reg_store

// ==== core/aacr_ctrl_regs.sv ====
// aacr_ctrl_regs: control register bank at 0x02..0x07 with decoded outputs.
// assumes the control-port byte engine supplies addr/data/strobe on i_sys_clk.
`timescale 1ns/1ps
module aacr_ctrl_regs (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    input  wire logic        i_wr_en,
    input  wire logic        i_rd_en,
    input  wire logic [7:0]  i_addr,
    input  wire logic [7:0]  i_wr_data,
    output logic [7:0]       o_rd_data,
    output logic             o_rd_valid,
    output logic             o_hpf_bypass,
    output logic [4:0]       o_boost_db,
    output logic             o_double_rate,
    output logic [2:0]       o_input_format,
    output logic             o_format_reserved,
    output logic             o_fade_en,
    output logic             o_mute_left,
    output logic             o_mute_right,
    output logic             o_half_duty_left,
    output logic             o_half_duty_right,
    output logic [7:0]       o_left_volume,
    output logic [7:0]       o_right_volume,
    output logic             o_parallel_bridge_mode,
    output logic [4:0]       o_frame_mult,
    output logic             o_rate_halved,
    output logic [1:0]       o_analog_gain,
    output logic             o_gain_reserved,
    output logic             o_parallel_bridge_mode_use_right
);
    aacr_reg_if rif ();
    logic [7:0] slot [6];
    logic       in_range;
    logic       rd_pend_ff;
    logic [7:0] dig_ctrl;
    logic [7:0] vol_cfg;
    logic [7:0] left_vol;
    logic [7:0] right_vol;
    logic [7:0] out_stage;

    function automatic logic in_window(input logic [7:0] a);
        in_window = (a >= aacr_pkg::ADDR_DIG_CTRL) && (a <= aacr_pkg::ADDR_RSVD_SLOT);
    endfunction

    function automatic logic [2:0] slot_of(input logic [7:0] a);
        slot_of = 3'(a - aacr_pkg::ADDR_DIG_CTRL);
    endfunction

    assign in_range = in_window(i_addr);

    // window 0x02..0x07 maps to slots 0..5; 0x07 writes are dropped, so slot 5 stays zero
    assign rif.wr_en   = i_wr_en && in_range && (i_addr != aacr_pkg::ADDR_RSVD_SLOT);
    assign rif.wr_idx  = slot_of(i_addr);
    assign rif.wr_data = i_wr_data;
    // out-of-window reads steer to slot 7, which the store answers with zero
    assign rif.rd_idx  = in_range ? slot_of(i_addr) : 3'd7;

    // named views of the store slots
    assign dig_ctrl  = slot[0];
    assign vol_cfg   = slot[1];
    assign left_vol  = slot[2];
    assign right_vol = slot[3];
    assign out_stage = slot[4];

    aacr_reg_store u_store (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .bus       (rif.store),
        .o_slot    (slot)
    );

    function automatic logic [4:0] rate_mult(input logic [2:0] code);
        case (code)
            3'b000:  rate_mult = 5'd6;
            3'b001:  rate_mult = 5'd8;
            3'b010:  rate_mult = 5'd10;
            3'b011:  rate_mult = 5'd12;
            3'b100:  rate_mult = 5'd14;
            3'b101:  rate_mult = 5'd16;
            3'b110:  rate_mult = 5'd20;
            default: rate_mult = 5'd24;
        endcase
    endfunction

    function automatic logic vol_muted(input logic [7:0] v);
        vol_muted = v < aacr_pkg::VOL_MUTE_LIMIT;
    endfunction

    // read data two cycles after the request, from the store register
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            rd_pend_ff <= 1'b0;
            o_rd_valid <= 1'b0;
        end else begin
            rd_pend_ff <= i_rd_en;
            o_rd_valid <= rd_pend_ff;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_rd_data <= 8'h00;
        end else if (rd_pend_ff) begin
            o_rd_data <= rif.rd_data;
        end
    end

    function automatic logic [4:0] boost_db(input logic [1:0] code);
        boost_db = 5'(code) * 5'd6;
    endfunction

    function automatic logic fmt_reserved(input logic [2:0] code);
        fmt_reserved = code > aacr_pkg::AACR_FMT_LJ;
    endfunction

    function automatic logic gain_reserved(input logic [1:0] code);
        gain_reserved = &code;
    endfunction

    function automatic logic pick_right(input logic [7:0] stage);
        pick_right = stage[aacr_pkg::PARALLEL_BRIDGE_MODE_BIT] && stage[aacr_pkg::CHSEL_BIT];
    endfunction

    // outputs decode the reset contents while reset is held, so no step appears at release
    localparam logic [4:0] RST_BOOST    = boost_db(aacr_pkg::RST_DIG_CTRL[aacr_pkg::BOOST_LSB +: 2]);
    localparam logic [2:0] RST_FORMAT   = aacr_pkg::RST_DIG_CTRL[aacr_pkg::FMT_LSB +: 3];
    localparam logic       RST_FMT_RSVD = fmt_reserved(aacr_pkg::RST_DIG_CTRL[aacr_pkg::FMT_LSB +: 3]);
    localparam logic       RST_MUTE_L   = aacr_pkg::RST_VOL_CFG[aacr_pkg::MUTE_L_BIT]
                                          || vol_muted(aacr_pkg::RST_VOLUME);
    localparam logic       RST_MUTE_R   = aacr_pkg::RST_VOL_CFG[aacr_pkg::MUTE_R_BIT]
                                          || vol_muted(aacr_pkg::RST_VOLUME);
    localparam logic [4:0] RST_MULT     = rate_mult(aacr_pkg::RST_OUT_STAGE[aacr_pkg::RATE_LSB +: 3]);
    localparam logic [1:0] RST_GAIN     = aacr_pkg::RST_OUT_STAGE[aacr_pkg::AGAIN_LSB +: 2];
    localparam logic       RST_GAIN_RSV = gain_reserved(aacr_pkg::RST_OUT_STAGE[aacr_pkg::AGAIN_LSB +: 2]);
    localparam logic       RST_USE_R    = pick_right(aacr_pkg::RST_OUT_STAGE);

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_hpf_bypass <= aacr_pkg::RST_DIG_CTRL[aacr_pkg::HPF_BYP_BIT];
        end else begin
            o_hpf_bypass <= dig_ctrl[aacr_pkg::HPF_BYP_BIT];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_boost_db <= RST_BOOST;
        end else begin
            o_boost_db <= boost_db(dig_ctrl[aacr_pkg::BOOST_LSB +: 2]);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_double_rate <= aacr_pkg::RST_DIG_CTRL[aacr_pkg::SPEED_BIT];
        end else begin
            o_double_rate <= dig_ctrl[aacr_pkg::SPEED_BIT];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_input_format <= RST_FORMAT;
        end else begin
            o_input_format <= dig_ctrl[aacr_pkg::FMT_LSB +: 3];
        end
    end

    // flag reserved codes; the host is trusted, this only makes a slip visible
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_format_reserved <= RST_FMT_RSVD;
        end else begin
            o_format_reserved <= fmt_reserved(dig_ctrl[aacr_pkg::FMT_LSB +: 3]);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_fade_en <= aacr_pkg::RST_VOL_CFG[aacr_pkg::FADE_BIT];
        end else begin
            o_fade_en <= vol_cfg[aacr_pkg::FADE_BIT];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_mute_right <= RST_MUTE_R;
        end else begin
            o_mute_right <= vol_cfg[aacr_pkg::MUTE_R_BIT] || vol_muted(right_vol);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_mute_left <= RST_MUTE_L;
        end else begin
            o_mute_left <= vol_cfg[aacr_pkg::MUTE_L_BIT] || vol_muted(left_vol);
        end
    end

    // soft mute idles right at half duty; a low volume code does not
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_half_duty_right <= aacr_pkg::RST_VOL_CFG[aacr_pkg::MUTE_R_BIT];
        end else begin
            o_half_duty_right <= vol_cfg[aacr_pkg::MUTE_R_BIT];
        end
    end

    // soft mute idles left at half duty
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_half_duty_left <= aacr_pkg::RST_VOL_CFG[aacr_pkg::MUTE_L_BIT];
        end else begin
            o_half_duty_left <= vol_cfg[aacr_pkg::MUTE_L_BIT];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_left_volume <= aacr_pkg::VOL_ZERO_DB;
        end else begin
            o_left_volume <= left_vol;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_right_volume <= aacr_pkg::VOL_ZERO_DB;
        end else begin
            o_right_volume <= right_vol;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_parallel_bridge_mode <= aacr_pkg::RST_OUT_STAGE[aacr_pkg::PARALLEL_BRIDGE_MODE_BIT];
        end else begin
            o_parallel_bridge_mode <= out_stage[aacr_pkg::PARALLEL_BRIDGE_MODE_BIT];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_frame_mult <= RST_MULT;
        end else begin
            o_frame_mult <= rate_mult(out_stage[aacr_pkg::RATE_LSB +: 3]);
        end
    end

    // halve in double rate; the modulator divides, we only flag it
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_rate_halved <= aacr_pkg::RST_DIG_CTRL[aacr_pkg::SPEED_BIT];
        end else begin
            o_rate_halved <= dig_ctrl[aacr_pkg::SPEED_BIT];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_analog_gain <= RST_GAIN;
        end else begin
            o_analog_gain <= out_stage[aacr_pkg::AGAIN_LSB +: 2];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_gain_reserved <= RST_GAIN_RSV;
        end else begin
            o_gain_reserved <= gain_reserved(out_stage[aacr_pkg::AGAIN_LSB +: 2]);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_parallel_bridge_mode_use_right <= RST_USE_R;
        end else begin
            o_parallel_bridge_mode_use_right <= pick_right(out_stage);
        end
    end
endmodule // aacr_ctrl_regs

// ==== sim/aacr_host_model.sv ====
// aacr_host_model: control-port host issuing byte writes and reads.
// assumes the bank takes a strobe on the rising edge of i_sys_clk.
`timescale 1ns/1ps
module aacr_host_model (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rd_valid,
    input  wire logic [7:0] i_rd_data,
    output logic            o_wr_en,
    output logic            o_rd_en,
    output logic [7:0]      o_addr,
    output logic [7:0]      o_wr_data
);
    initial begin
        {o_wr_en, o_rd_en, o_addr, o_wr_data} = '0;
    end
    // released lines show the inverse so a stale value never passes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        {o_wr_en, o_addr, o_wr_data} <= {1'b1, a, d};
        @(posedge i_sys_clk);
        {o_wr_en, o_addr, o_wr_data} <= {1'b0, ~a, ~d};
    endtask
    // address held until the answer, though the bank samples it only on the read strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_sys_clk);
        {o_rd_en, o_addr} <= {1'b1, a};
        @(posedge i_sys_clk);
        o_rd_en <= 1'b0;
        for (int i = 0; i < 6 && i_rd_valid !== 1'b1; i++)
            @(posedge i_sys_clk);
        // a missing answer hands back unknown so the caller's compare trips
        d = (i_rd_valid === 1'b1) ? i_rd_data : 8'hxx;
        o_addr <= ~a;
    endtask
endmodule // aacr_host_model

// ==== sim/aacr_ctrl_chk.sv ====
// aacr_ctrl_chk: port assertions for the control register bank.
// assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module aacr_ctrl_chk (
    input wire logic       i_sys_clk,
    input wire logic       i_rst,
    input wire logic       i_wr_en,
    input wire logic       i_rd_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic       o_rd_valid,
    input wire logic       o_hpf_bypass,
    input wire logic [4:0] o_boost_db,
    input wire logic [7:0] o_left_volume,
    input wire logic       o_mute_left,
    input wire logic       o_half_duty_left,
    input wire logic       o_parallel_bridge_mode,
    input wire logic       o_parallel_bridge_mode_use_right,
    input wire logic       o_rate_halved,
    input wire logic       o_double_rate
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    sequence wr_to(a);
        i_wr_en && i_addr == a;
    endsequence
    chk_hpf_follow: assert property (wr_to(8'h02) |-> ##2 o_hpf_bypass == $past(i_wr_data[7], 2))
        else $error("hpf bypass");
    chk_boost_step: assert property (wr_to(8'h02) |-> ##2 o_boost_db == 5'(6 * $past(i_wr_data[5:4], 2)))
        else $error("boost");
    chk_left_vol: assert property (wr_to(8'h04) |-> ##2 o_left_volume == $past(i_wr_data, 2))
        else $error("left volume");
    chk_mute_low_vol: assert property (o_mute_left == (o_half_duty_left || o_left_volume < 8'h07))
        else $error("left mute");
    chk_parallel_bridge_mode_follow: assert property (wr_to(8'h06) |-> ##2 o_parallel_bridge_mode == $past(i_wr_data[7], 2))
        else $error("bridge mode");
    chk_chan_select: assert property (o_parallel_bridge_mode_use_right |-> o_parallel_bridge_mode)
        else $error("channel select");
    chk_rate_halved: assert property (o_rate_halved == o_double_rate)
        else $error("rate halved");
    chk_read_answer: assert property (i_rd_en |-> ##2 o_rd_valid)
        else $error("read answer");
endmodule // aacr_ctrl_chk
bind aacr_ctrl_regs aacr_ctrl_chk aacr_ctrl_chk_inst (.*);

// ==== sim/tb_audio_amp_control_registers.sv ====
// tb_audio_amp_control_registers: self-checking bench against a register model.
// assumes package, design, host model and checker are compiled first.
`timescale 1ns/1ps
module tb_audio_amp_control_registers;
    logic       i_sys_clk, i_rst, i_wr_en, i_rd_en, o_rd_valid, o_hpf_bypass, o_double_rate, o_format_reserved;
    logic       o_fade_en, o_mute_left, o_mute_right, o_half_duty_left, o_half_duty_right, o_parallel_bridge_mode;
    logic       o_rate_halved, o_gain_reserved, o_parallel_bridge_mode_use_right;
    logic [7:0] i_addr, i_wr_data, o_rd_data, o_left_volume, o_right_volume, r, wa, wd;
    logic [4:0] o_boost_db, o_frame_mult;
    logic [2:0] o_input_format;
    logic [1:0] o_analog_gain;
    logic [7:0] m [8] = '{8'h00, 8'h00, 8'h14, 8'h80, 8'hcf, 8'hcf, 8'h51, 8'h00};
    logic [7:0] wm [8] = '{8'h00, 8'h00, 8'hbf, 8'h83, 8'hff, 8'hff, 8'hfe, 8'h00};
    int         mult [8] = '{6, 8, 10, 12, 14, 16, 20, 24};
    int         n_mismatch = 0, comparisons = 0, seed = 32'ha249;
    wire [42:0] obs = {o_hpf_bypass, o_boost_db, o_double_rate, o_input_format, o_format_reserved, o_fade_en,
        o_mute_left, o_mute_right, o_half_duty_left, o_half_duty_right, o_left_volume, o_right_volume,
        o_parallel_bridge_mode, o_frame_mult, o_rate_halved, o_analog_gain, o_gain_reserved, o_parallel_bridge_mode_use_right};
    wire [42:0] expv = {m[2][7], 5'(6 * m[2][5:4]), m[2][3], m[2][2:0], m[2][2:0] > 3'd5, m[3][7],
        m[3][0] || m[4] < 8'h07, m[3][1] || m[5] < 8'h07, m[3][0], m[3][1], m[4], m[5], m[6][7],
        5'(mult[m[6][6:4]]), m[2][3], m[6][3:2], &m[6][3:2], m[6][7] & m[6][1]};
    aacr_ctrl_regs aacr_ctrl_regs_inst (.*);
    aacr_host_model aacr_host_model_inst (.i_sys_clk(i_sys_clk), .i_rd_valid(o_rd_valid), .i_rd_data(o_rd_data),
        .o_wr_en(i_wr_en), .o_rd_en(i_rd_en), .o_addr(i_addr), .o_wr_data(i_wr_data));
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        comparisons++;
        if (seen !== want) begin
            n_mismatch++;
            $display("Error at %0t: seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic rd_check(input logic [7:0] a);
        aacr_host_model_inst.rd(a, r);
        check(r, a < 8 ? m[a[2:0]] : 8'h00);
        check(obs, expv);
    endtask
    task automatic op(input logic [7:0] a, input logic [7:0] d);
        aacr_host_model_inst.wr(a, d);
        if (a < 8)
            m[a[2:0]] = m[a[2:0]] & ~wm[a[2:0]] | d & wm[a[2:0]];
        rd_check(a);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        i_sys_clk = 1'b0;
        forever #4 i_sys_clk = ~i_sys_clk;
    end
    initial begin
        #400000;
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        i_rst = 1'b1;
        repeat (12) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        for (int k = 2; k < 10; k++)
            rd_check(8'(k));
        $display("test reset values done");
        // volumes walk across the mute limit, every rate code, format codes 0..5 and gain codes 0..2
        for (int c = 0; c < 8; c++) begin
            op(8'h06, {c[2], 3'(c), 2'(c % 3), c[0], 1'b1});
            op(8'h02, {c[0], 1'b0, c[1:0], c[1], 3'(c % 6)});
            op(8'h03, {c[2], 5'h00, c[1:0]});
            op(8'h04, 8'(c + 3));
            op(8'h05, 8'(10 - c));
        end
        $display("test field codes done");
        // read-only bits, reserved slot and unmapped address refuse writes
        op(8'h03, 8'hff);
        op(8'h02, 8'h40);
        op(8'h06, 8'h00);
        op(8'h07, 8'hff);
        op(8'h09, 8'h5a);
        $display("test refused writes done");
        for (int i = 0; i < 40; i++) begin
            wa = 8'(2 + {$random(seed)} % 5);
            wd = 8'($random(seed));
            // reserved bits kept, reserved codes avoided
            wd = wd & wm[wa[2:0]] | m[wa[2:0]] & ~wm[wa[2:0]];
            if (wa == 8'h02 && wd[2:0] > 3'd5)
                wd[1] = 1'b0;
            if (wa == 8'h06 && &wd[3:2])
                wd[3] = 1'b0;
            op(wa, wd);
        end
        $display("test random traffic done");
        tally_and_finish();
    end
endmodule // tb_audio_amp_control_registers
